/* File: tcrc_pkg.sv */
// shared constants and types for the timer capture, reload and compare block
package tcrc_pkg;

	// register byte addresses on the special-function bus
	localparam logic [7:0] ADDR_CAP_CTRL  = 8'h92;
	localparam logic [7:0] ADDR_EDGE_SEL  = 8'h93;
	localparam logic [7:0] ADDR_FILT_EN   = 8'h94;
	localparam logic [7:0] ADDR_CTRL      = 8'hc8;
	localparam logic [7:0] ADDR_MODE      = 8'hc9;
	localparam logic [7:0] ADDR_RC_LOW    = 8'hca;
	localparam logic [7:0] ADDR_RC_HIGH   = 8'hcb;
	localparam logic [7:0] ADDR_CNT_LOW   = 8'hcc;
	localparam logic [7:0] ADDR_CNT_HIGH  = 8'hcd;
	localparam logic [7:0] ADDR_CAP0_LOW  = 8'he4;
	localparam logic [7:0] ADDR_CAP0_HIGH = 8'he5;
	localparam logic [7:0] ADDR_CAP1_LOW  = 8'he6;
	localparam logic [7:0] ADDR_CAP1_HIGH = 8'he7;
	localparam logic [7:0] ADDR_CAP2_LOW  = 8'hed;
	localparam logic [7:0] ADDR_CAP2_HIGH = 8'hee;
	localparam logic [7:0] ADDR_INT_STAT  = 8'hf8;
	localparam logic [7:0] ADDR_INT_MASK  = 8'hf9;

	// field positions
	localparam int CAP_FLAG_LSB   = 0;
	localparam int CAP_EN_LSB     = 4;
	localparam int FILT_EN_LSB    = 4;
	localparam int CTRL_CMP_SEL   = 0;
	localparam int CTRL_RUN       = 2;
	localparam int CTRL_MATCH     = 7;
	localparam int MODE_TRIG_LSB  = 0;
	localparam int MODE_CLR_MATCH = 2;
	localparam int MODE_CLR_CAP   = 3;
	localparam int MODE_RELOAD_EN = 7;
	localparam int INT_MATCH      = 3;
	localparam int INT_OVF        = 4;

	// reset values and the counter maximum
	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hffff;

	// channel count, interrupt status width and filter length in cpu clocks
	localparam int          NUM_CHAN      = 3;
	localparam int          INT_BITS      = 5;
	localparam int          FILT_CLKS     = 4;
	localparam logic [1:0]  FILT_LAST     = 2'(FILT_CLKS - 1);

	// edge selection codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] EDGE_RSVD = 2'h3;

	// reload trigger codes
	localparam logic [1:0] TRIG_OVF  = 2'h0;
	localparam logic [1:0] TRIG_CAP0 = 2'h1;
	localparam logic [1:0] TRIG_CAP1 = 2'h2;
	localparam logic [1:0] TRIG_CAP2 = 2'h3;

	typedef enum logic [2:0] {
		TCRC_MODE_CAPTURE = 3'b001,
		TCRC_MODE_RELOAD  = 3'b010,
		TCRC_MODE_COMPARE = 3'b100
	} tcrc_mode_t;

	typedef struct packed {
		logic [1:0] edge_code;
		logic       filter_on;
	} tcrc_chan_cfg_t;

endpackage : tcrc_pkg

/* File: tcrc_chan.sv */
// one capture channel front end: optional glitch filter and edge detector
`timescale 1ns/1ps
module tcrc_chan (
	input  wire logic                    mclk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    ce_in,
	input  wire logic                    pin_in,
	input  wire tcrc_pkg::tcrc_chan_cfg_t cfg_in,
	output logic                         cap_pulse_out
);

	typedef struct packed {
		logic       smp;
		logic       lvl;
		logic       prev;
		logic [1:0] cnt;
		logic       pulse;
	} tcrc_chan_st_t;

	tcrc_chan_st_t st_ff;
	tcrc_chan_st_t nxt_st;

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.smp = pin_in;
		if (cfg_in.filter_on) begin
			if (st_ff.smp == st_ff.lvl) begin
				nxt_st.cnt = 2'h0;
			end else if (st_ff.cnt == tcrc_pkg::FILT_LAST) begin
				nxt_st.lvl = st_ff.smp;
				nxt_st.cnt = 2'h0;
			end else begin
				nxt_st.cnt = st_ff.cnt + 2'h1;
			end
		end else begin
			nxt_st.lvl = st_ff.smp;
			nxt_st.cnt = 2'h0;
		end
		nxt_st.prev = st_ff.lvl;
		unique case (cfg_in.edge_code)
			tcrc_pkg::EDGE_FALL: nxt_st.pulse = st_ff.prev & ~st_ff.lvl;
			tcrc_pkg::EDGE_RISE: nxt_st.pulse = ~st_ff.prev & st_ff.lvl;
			tcrc_pkg::EDGE_BOTH: nxt_st.pulse = st_ff.prev ^ st_ff.lvl;
			tcrc_pkg::EDGE_RSVD: nxt_st.pulse = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	assign cap_pulse_out = st_ff.pulse;

endmodule : tcrc_chan

/* File: tcrc_top.sv */
// timer capture, auto-reload and compare block with its register port
// Behaviour
// - each channel has a two-bit edge code: 00 falling, 01 rising, 10 either edge, 11 reserved.
// - the filter enable register holds one filter enable per channel in bits 6 to 4 for channels 2 to 0.
// - each channel keeps a 16-bit result as readable and writable low and high bytes that reset to zero.
// - with compare select zero and reload enable one the timer is in auto-reload mode using the reload pair.
// - in auto-reload mode each reload event copies the reload bytes into the counter bytes.
// - the reload event is overflow or one capture channel, chosen by the two-bit trigger select.
// - outside compare mode, with clear-on-capture set a capture event clears the counter to zero instead of reloading it.
// - compare select set gives compare mode regardless of reload enable, the pair being the compare value.
// - in compare mode a running counter equal to the compare value sets the match flag in control bit 7.
// - with clear-on-match set the counter is cleared to zero after each compare match.
// - input capture mode holds when compare select and reload enable are both zero.
// - a selected edge on an enabled channel copies the counter into its result and sets its flag.
// - an enabled filter rejects pulses shorter than four clocks before edge detection.
// - trigger select 00 is overflow and 01, 10, 11 are capture channels 0, 1 and 2.
`timescale 1ns/1ps
module tcrc_top (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic       capture_pin_zero_in,
	input  wire logic       capture_pin_one_in,
	input  wire logic       capture_pin_two_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       wr_en_in,
	input  wire logic       rd_en_in,
	output logic      [7:0] rd_data_out,
	output logic            irq_out
);

	localparam int NC = tcrc_pkg::NUM_CHAN;
	localparam int NI = tcrc_pkg::INT_BITS;

	typedef struct packed {
		logic [7:0]           edge_sel;
		logic [7:0]           filt_en;
		logic [NC-1:0]        cap_en;
		logic [NC-1:0]        cap_flag;
		logic [NC-1:0][15:0]  cap;
		logic [15:0]          rc;
		logic [15:0]          cnt;
		logic                 cmp_sel;
		logic                 run;
		logic                 match_flag;
		logic                 reload_en;
		logic                 clr_cap;
		logic                 clr_match;
		logic [1:0]           trig_sel;
		logic [NI-1:0]        int_stat;
		logic [NI-1:0]        int_mask;
		logic [7:0]           rd_data;
		logic                 irq;
	} tcrc_state_t;

	tcrc_state_t st_ff;
	tcrc_state_t nxt_st;

	logic [NC-1:0]                 pins;
	logic [NC-1:0]                 edge_pulse;
	tcrc_pkg::tcrc_chan_cfg_t [NC-1:0] chan_cfg;

	assign pins = {capture_pin_two_in, capture_pin_one_in, capture_pin_zero_in};

	// one front end per channel
	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_chan
			assign chan_cfg[gi] = {st_ff.edge_sel[2*gi +: 2], st_ff.filt_en[tcrc_pkg::FILT_EN_LSB + gi]};
			tcrc_chan u_chan (
				.mclk_in       (mclk_in),
				.rst_n_in      (rst_n_in),
				.ce_in         (ce_in),
				.pin_in        (pins[gi]),
				.cfg_in        (chan_cfg[gi]),
				.cap_pulse_out (edge_pulse[gi])
			);
		end
	endgenerate

	tcrc_pkg::tcrc_mode_t mode;
	logic [NC-1:0]        cap_evt;
	logic                 any_cap;
	logic                 overflow;
	logic                 match;
	logic                 reload_evt;
	logic                 wr_low;
	logic                 wr_high;
	logic [NI-1:0]        int_set;
	logic [7:0]           rd_mux;

	// mode decode from the two select bits
	always_comb begin
		if (st_ff.cmp_sel) begin
			mode = tcrc_pkg::TCRC_MODE_COMPARE;
		end else if (st_ff.reload_en) begin
			mode = tcrc_pkg::TCRC_MODE_RELOAD;
		end else begin
			mode = tcrc_pkg::TCRC_MODE_CAPTURE;
		end
	end

	assign cap_evt  = edge_pulse & st_ff.cap_en;
	assign any_cap  = |cap_evt;
	assign overflow = st_ff.run && (st_ff.cnt == tcrc_pkg::CNT_MAX);
	assign match    = st_ff.run && (mode == tcrc_pkg::TCRC_MODE_COMPARE) && (st_ff.cnt == st_ff.rc);

	always_comb begin
		unique case (st_ff.trig_sel)
			tcrc_pkg::TRIG_OVF:  reload_evt = overflow;
			tcrc_pkg::TRIG_CAP0: reload_evt = cap_evt[0];
			tcrc_pkg::TRIG_CAP1: reload_evt = cap_evt[1];
			tcrc_pkg::TRIG_CAP2: reload_evt = cap_evt[2];
		endcase
	end

	assign int_set = {overflow, match, cap_evt};

	// read multiplexer; unmapped addresses read as zero
	always_comb begin
		rd_mux = tcrc_pkg::REG_RESET;
		unique case (addr_in)
			tcrc_pkg::ADDR_CAP_CTRL: begin
				rd_mux[tcrc_pkg::CAP_EN_LSB +: NC]   = st_ff.cap_en;
				rd_mux[tcrc_pkg::CAP_FLAG_LSB +: NC] = st_ff.cap_flag;
			end
			tcrc_pkg::ADDR_EDGE_SEL:  rd_mux = st_ff.edge_sel;
			tcrc_pkg::ADDR_FILT_EN:   rd_mux = st_ff.filt_en;
			tcrc_pkg::ADDR_CTRL: begin
				rd_mux[tcrc_pkg::CTRL_MATCH]   = st_ff.match_flag;
				rd_mux[tcrc_pkg::CTRL_RUN]     = st_ff.run;
				rd_mux[tcrc_pkg::CTRL_CMP_SEL] = st_ff.cmp_sel;
			end
			tcrc_pkg::ADDR_MODE: begin
				rd_mux[tcrc_pkg::MODE_RELOAD_EN]     = st_ff.reload_en;
				rd_mux[tcrc_pkg::MODE_CLR_CAP]       = st_ff.clr_cap;
				rd_mux[tcrc_pkg::MODE_CLR_MATCH]     = st_ff.clr_match;
				rd_mux[tcrc_pkg::MODE_TRIG_LSB +: 2] = st_ff.trig_sel;
			end
			tcrc_pkg::ADDR_RC_LOW:    rd_mux = st_ff.rc[7:0];
			tcrc_pkg::ADDR_RC_HIGH:   rd_mux = st_ff.rc[15:8];
			tcrc_pkg::ADDR_CNT_LOW:   rd_mux = st_ff.cnt[7:0];
			tcrc_pkg::ADDR_CNT_HIGH:  rd_mux = st_ff.cnt[15:8];
			tcrc_pkg::ADDR_CAP0_LOW:  rd_mux = st_ff.cap[0][7:0];
			tcrc_pkg::ADDR_CAP0_HIGH: rd_mux = st_ff.cap[0][15:8];
			tcrc_pkg::ADDR_CAP1_LOW:  rd_mux = st_ff.cap[1][7:0];
			tcrc_pkg::ADDR_CAP1_HIGH: rd_mux = st_ff.cap[1][15:8];
			tcrc_pkg::ADDR_CAP2_LOW:  rd_mux = st_ff.cap[2][7:0];
			tcrc_pkg::ADDR_CAP2_HIGH: rd_mux = st_ff.cap[2][15:8];
			tcrc_pkg::ADDR_INT_STAT:  rd_mux[NI-1:0] = st_ff.int_stat;
			tcrc_pkg::ADDR_INT_MASK:  rd_mux[NI-1:0] = st_ff.int_mask;
			default:                  rd_mux = tcrc_pkg::REG_RESET;
		endcase
	end

	assign wr_low  = wr_en_in && (addr_in == tcrc_pkg::ADDR_CNT_LOW);
	assign wr_high = wr_en_in && (addr_in == tcrc_pkg::ADDR_CNT_HIGH);

	always_comb begin
		nxt_st = st_ff;

		// software writes; hardware updates below take priority where they meet
		if (wr_en_in) begin
			unique case (addr_in)
				tcrc_pkg::ADDR_CAP_CTRL: begin
					nxt_st.cap_en   = wr_data_in[tcrc_pkg::CAP_EN_LSB +: NC];
					nxt_st.cap_flag = wr_data_in[tcrc_pkg::CAP_FLAG_LSB +: NC];
				end
				tcrc_pkg::ADDR_EDGE_SEL: nxt_st.edge_sel = {2'h0, wr_data_in[5:0]};
				tcrc_pkg::ADDR_FILT_EN: begin
					nxt_st.filt_en = tcrc_pkg::REG_RESET;
					nxt_st.filt_en[tcrc_pkg::FILT_EN_LSB +: NC] = wr_data_in[tcrc_pkg::FILT_EN_LSB +: NC];
				end
				tcrc_pkg::ADDR_CTRL: begin
					nxt_st.match_flag = wr_data_in[tcrc_pkg::CTRL_MATCH];
					nxt_st.run        = wr_data_in[tcrc_pkg::CTRL_RUN];
					nxt_st.cmp_sel    = wr_data_in[tcrc_pkg::CTRL_CMP_SEL];
				end
				tcrc_pkg::ADDR_MODE: begin
					nxt_st.reload_en = wr_data_in[tcrc_pkg::MODE_RELOAD_EN];
					nxt_st.clr_cap   = wr_data_in[tcrc_pkg::MODE_CLR_CAP];
					nxt_st.clr_match = wr_data_in[tcrc_pkg::MODE_CLR_MATCH];
					nxt_st.trig_sel  = wr_data_in[tcrc_pkg::MODE_TRIG_LSB +: 2];
				end
				tcrc_pkg::ADDR_RC_LOW:    nxt_st.rc[7:0]      = wr_data_in;
				tcrc_pkg::ADDR_RC_HIGH:   nxt_st.rc[15:8]     = wr_data_in;
				tcrc_pkg::ADDR_CAP0_LOW:  nxt_st.cap[0][7:0]  = wr_data_in;
				tcrc_pkg::ADDR_CAP0_HIGH: nxt_st.cap[0][15:8] = wr_data_in;
				tcrc_pkg::ADDR_CAP1_LOW:  nxt_st.cap[1][7:0]  = wr_data_in;
				tcrc_pkg::ADDR_CAP1_HIGH: nxt_st.cap[1][15:8] = wr_data_in;
				tcrc_pkg::ADDR_CAP2_LOW:  nxt_st.cap[2][7:0]  = wr_data_in;
				tcrc_pkg::ADDR_CAP2_HIGH: nxt_st.cap[2][15:8] = wr_data_in;
				tcrc_pkg::ADDR_INT_MASK:  nxt_st.int_mask     = wr_data_in[NI-1:0];
				default: ;
			endcase
		end

		// counter: increment, then events override in order of strength
		if (st_ff.run) begin
			nxt_st.cnt = st_ff.cnt + 16'h0001;
		end
		if ((mode == tcrc_pkg::TCRC_MODE_RELOAD) && reload_evt) begin
			nxt_st.cnt = st_ff.rc;
		end
		if ((mode != tcrc_pkg::TCRC_MODE_COMPARE) && any_cap && st_ff.clr_cap) begin
			nxt_st.cnt = tcrc_pkg::WORD_RESET;
		end
		if (match && st_ff.clr_match) begin
			nxt_st.cnt = tcrc_pkg::WORD_RESET;
		end
		// a direct byte write wins over counting; software should stop the timer first
		if (wr_low) begin
			nxt_st.cnt[7:0] = wr_data_in;
		end
		if (wr_high) begin
			nxt_st.cnt[15:8] = wr_data_in;
		end

		if (match) begin
			nxt_st.match_flag = 1'b1;
		end

		for (int i = 0; i < NC; i++) begin
			if (cap_evt[i]) begin
				nxt_st.cap[i]      = st_ff.cnt;
				nxt_st.cap_flag[i] = 1'b1;
			end
		end

		// status clears on read, a new event in the same cycle survives
		if (rd_en_in && (addr_in == tcrc_pkg::ADDR_INT_STAT)) begin
			nxt_st.int_stat = int_set;
		end else begin
			nxt_st.int_stat = st_ff.int_stat | int_set;
		end

		nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);

		// read data stands only in the cycle after the strobe
		if (rd_en_in) begin
			nxt_st.rd_data = rd_mux;
		end else begin
			nxt_st.rd_data = tcrc_pkg::REG_RESET;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	assign rd_data_out = st_ff.rd_data;
	assign irq_out     = st_ff.irq;

endmodule : tcrc_top

/* File: tcrc_monitor.sv */
// port assertions for the timer capture, reload and compare block
`timescale 1ns/1ps
module tcrc_monitor (
	input wire logic       mclk_in,
	input wire logic       rst_n_in,
	input wire logic       ce_in,
	input wire logic       capture_pin_zero_in,
	input wire logic       capture_pin_one_in,
	input wire logic       capture_pin_two_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic       wr_en_in,
	input wire logic       rd_en_in,
	input wire logic [7:0] rd_data_out,
	input wire logic       irq_out
);
	logic [7:0] edge_ff;
	logic [7:0] filt_ff;
	logic [7:0] rc_ff;
	logic [7:0] mask_ff;
	logic       wr_ok;
	assign wr_ok = wr_en_in && ce_in;
	// software-owned registers shadowed so readback has a reference
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			edge_ff <= 8'h00;
			filt_ff <= 8'h00;
			rc_ff <= 8'h00;
			mask_ff <= 8'h00;
		end else begin
			if (wr_ok && addr_in == tcrc_pkg::ADDR_EDGE_SEL) edge_ff <= wr_data_in;
			if (wr_ok && addr_in == tcrc_pkg::ADDR_FILT_EN) filt_ff <= wr_data_in;
			if (wr_ok && addr_in == tcrc_pkg::ADDR_RC_LOW) rc_ff <= wr_data_in;
			if (wr_ok && addr_in == tcrc_pkg::ADDR_INT_MASK) mask_ff <= wr_data_in;
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	chk_read_idle: assert property (
		!$past(rd_en_in) |-> rd_data_out == 8'h00) else $error("read data not idle");
	chk_unmapped_zero: assert property (
		rd_en_in && addr_in == 8'h00 |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
	chk_edge_readback: assert property (
		rd_en_in && addr_in == tcrc_pkg::ADDR_EDGE_SEL |=> rd_data_out == {2'h0, edge_ff[5:0]})
		else $error("edge select readback wrong");
	chk_filter_readback: assert property (
		rd_en_in && addr_in == tcrc_pkg::ADDR_FILT_EN |=> rd_data_out == {1'b0, filt_ff[6:4], 4'h0})
		else $error("filter enable readback wrong");
	chk_reload_readback: assert property (
		rd_en_in && addr_in == tcrc_pkg::ADDR_RC_LOW |=> rd_data_out == rc_ff)
		else $error("reload low readback wrong");
	chk_capctl_reserved: assert property (
		rd_en_in && addr_in == tcrc_pkg::ADDR_CAP_CTRL |=> !rd_data_out[7] && !rd_data_out[3])
		else $error("capture control reserved bits set");
	chk_reset_quiet: assert property (
		$rose(rst_n_in) |-> rd_data_out == 8'h00 && !irq_out) else $error("outputs busy after reset");
	chk_irq_masked: assert property (
		mask_ff == 8'h00 && $past(mask_ff) == 8'h00 |-> !irq_out) else $error("irq while fully masked");
	cover property (rd_en_in && addr_in == tcrc_pkg::ADDR_INT_STAT ##1 rd_data_out != 8'h00);
	cover property ($rose(irq_out));
	cover property (rd_en_in && addr_in == tcrc_pkg::ADDR_CTRL ##1 rd_data_out[7]);
endmodule : tcrc_monitor
bind tcrc_top tcrc_monitor tcrc_monitor_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
	.capture_pin_zero_in(capture_pin_zero_in), .capture_pin_one_in(capture_pin_one_in),
	.capture_pin_two_in(capture_pin_two_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .irq_out(irq_out));

/* File: tcrc_pin_model.sv */
// outside signal source for the three capture pins
`timescale 1ns/1ps
module tcrc_pin_model (
	input  wire logic       mclk_in,
	input  wire logic [2:0] level_in,
	input  wire logic       slow_in,
	output logic      [2:0] pin_out
);
	logic [2:0] hist_ff [3];
	// slow source lags two more cycles, pulse widths kept
	always_ff @(posedge mclk_in) begin
		hist_ff[0] <= level_in;
		hist_ff[1] <= hist_ff[0];
		hist_ff[2] <= hist_ff[1];
	end
	assign pin_out = slow_in ? hist_ff[2] : hist_ff[0];
endmodule : tcrc_pin_model

/* File: tb.sv */
// self-checking bench for the timer capture, reload and compare block
`timescale 1ns/1ps
module tb;
	logic        mclk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [2:0]  lvl = 3'h0;
	logic        slow = 1'b0;
	logic [2:0]  pins;
	logic [7:0]  rdata;
	logic        irq;
	logic [7:0]  d;
	logic [15:0] v;
	bit          hit;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cm;
	int          res_m[3];
	logic [7:0]  lo_a[3] = '{tcrc_pkg::ADDR_CAP0_LOW, tcrc_pkg::ADDR_CAP1_LOW, tcrc_pkg::ADDR_CAP2_LOW};
	logic [7:0]  hi_a[3] = '{tcrc_pkg::ADDR_CAP0_HIGH, tcrc_pkg::ADDR_CAP1_HIGH, tcrc_pkg::ADDR_CAP2_HIGH};
	always #2.5 mclk_in = ~mclk_in;
	tcrc_pin_model tcrc_pin_model_inst (.mclk_in(mclk_in), .level_in(lvl), .slow_in(slow), .pin_out(pins));
	tcrc_top tcrc_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.capture_pin_zero_in(pins[0]), .capture_pin_one_in(pins[1]), .capture_pin_two_in(pins[2]),
		.addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata), .irq_out(irq));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : cyc
	// strobe stays up: chained writes are back to back
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge mclk_in);
	endtask : wr_reg
	task automatic idle();
		wr <= 1'b0;
		@(posedge mclk_in);
	endtask : idle
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		// data stands for the whole next cycle; take it at its closing edge
		@(posedge mclk_in);
		q = rdata;
	endtask : rd_reg
	task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] q);
		rd_reg(lo, q[7:0]);
		rd_reg(hi, q[15:8]);
	endtask : rd16
	task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input int x);
		wr_reg(lo, 8'(x));
		wr_reg(hi, 8'(x >> 8));
	endtask : wr16
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		cyc(20000);
		num_errors++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hd0f26d96));
		cyc(8);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd16(lo_a[i], hi_a[i], v);
			chk("cap_reset", v, 16'h0000);
			res_m[i] = $urandom & 32'hffff;
			wr16(lo_a[i], hi_a[i], res_m[i]);
			rd16(lo_a[i], hi_a[i], v);
			chk("cap_rw", v, 16'(res_m[i]));
		end
		rd_reg(tcrc_pkg::ADDR_EDGE_SEL, d);
		rd_reg(tcrc_pkg::ADDR_FILT_EN, d);
		rd_reg(8'h00, d);
		chk("unmapped", 16'(d), 16'h0000);
		// counter held still so each capture value is known
		wr_reg(tcrc_pkg::ADDR_CAP_CTRL, 8'h70);
		for (int ch = 0; ch < 3; ch++) begin
			for (int c = 0; c < 4; c++) begin
				wr_reg(tcrc_pkg::ADDR_EDGE_SEL, 8'(c << (2 * ch)));
				for (int t = 0; t < 2; t++) begin
					v = 16'($urandom);
					wr16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, v);
					idle();
					lvl[ch] <= ~lvl[ch];
					cyc(12);
					hit = (c == 2) || (c == int'(lvl[ch]));
					if (hit) res_m[ch] = v;
					rd_reg(tcrc_pkg::ADDR_CAP_CTRL, d);
					chk("cap_flag", 16'(d[ch]), 16'(hit));
					rd16(lo_a[ch], hi_a[ch], v);
					chk("cap_value", v, 16'(res_m[ch]));
					wr_reg(tcrc_pkg::ADDR_CAP_CTRL, 8'h70);
				end
			end
		end
		rd_reg(tcrc_pkg::ADDR_INT_STAT, d);
		chk("int_stat", 16'(d), 16'h0007);
		rd_reg(tcrc_pkg::ADDR_INT_STAT, d);
		chk("int_clear", 16'(d), 16'h0000);
		wr_reg(tcrc_pkg::ADDR_INT_MASK, 8'h01);
		wr_reg(tcrc_pkg::ADDR_EDGE_SEL, 8'h15);
		idle();
		lvl <= 3'h1;
		cyc(12);
		chk("irq_on", 16'(irq), 16'h0001);
		rd_reg(tcrc_pkg::ADDR_INT_STAT, d);
		cyc(2);
		chk("irq_off", 16'(irq), 16'h0000);
		wr_reg(tcrc_pkg::ADDR_INT_MASK, 8'h00);
		wr_reg(tcrc_pkg::ADDR_FILT_EN, 8'h10);
		wr_reg(tcrc_pkg::ADDR_EDGE_SEL, 8'h02);
		wr_reg(tcrc_pkg::ADDR_CAP_CTRL, 8'h70);
		idle();
		slow <= 1'b1;
		for (int w = 3; w < 7; w += 3) begin
			lvl[0] <= 1'b0;
			cyc(w);
			lvl[0] <= 1'b1;
			cyc(15);
			rd_reg(tcrc_pkg::ADDR_CAP_CTRL, d);
			chk("filter", 16'(d[0]), 16'(w > 3));
		end
		wr_reg(tcrc_pkg::ADDR_FILT_EN, 8'h00);
		wr_reg(tcrc_pkg::ADDR_EDGE_SEL, 8'h2a);
		for (int tr = 0; tr < 4; tr++) begin
			cm = $urandom & 32'hffff;
			wr16(tcrc_pkg::ADDR_RC_LOW, tcrc_pkg::ADDR_RC_HIGH, cm);
			wr_reg(tcrc_pkg::ADDR_MODE, 8'(8'h80 | tr));
			wr16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, 32'hffff);
			// one-cycle run burst: exactly one overflow from all ones, which reloads the counter
			if (tr == 0) wr_reg(tcrc_pkg::ADDR_CTRL, 8'h04);
			if (tr == 0) wr_reg(tcrc_pkg::ADDR_CTRL, 8'h00);
			idle();
			if (tr == 0) lvl <= ~lvl;
			else lvl[tr - 1] <= ~lvl[tr - 1];
			cyc(12);
			rd_reg(tcrc_pkg::ADDR_RC_LOW, d);
			rd16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, v);
			chk("reload", v, 16'(cm));
		end
		wr_reg(tcrc_pkg::ADDR_MODE, 8'h89);
		wr_reg(tcrc_pkg::ADDR_CNT_HIGH, 8'h5a);
		idle();
		lvl[0] <= ~lvl[0];
		cyc(12);
		rd16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, v);
		chk("cap_clear", v, 16'h0000);
		for (int clr = 0; clr < 2; clr++) begin
			cm = $urandom & 32'hffff;
			wr_reg(tcrc_pkg::ADDR_CTRL, 8'h01);
			wr_reg(tcrc_pkg::ADDR_MODE, 8'(8'h80 | (clr << 2)));
			wr16(tcrc_pkg::ADDR_RC_LOW, tcrc_pkg::ADDR_RC_HIGH, cm);
			wr16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, cm);
			wr_reg(tcrc_pkg::ADDR_CTRL, 8'h05);
			wr_reg(tcrc_pkg::ADDR_CTRL, 8'h01);
			rd_reg(tcrc_pkg::ADDR_CTRL, d);
			chk("match_flag", 16'(d), 16'h0081);
			rd16(tcrc_pkg::ADDR_CNT_LOW, tcrc_pkg::ADDR_CNT_HIGH, v);
			chk("match_cnt", v, (clr == 1) ? 16'h0000 : 16'(cm + 1));
		end
		complete_run();
	end
endmodule : tb
